// ---- inc/psp_pkg.sv ----
/*
 * psp_pkg: register indices, field positions, reset values and carrier types
 * for the parallel slave port.
 * assumes: an 8-bit register port driven by the on-chip cpu, one clock domain.
 */
package psp_pkg;
    localparam int PSP_AW = 4;
    localparam logic [3:0] PSP_IDX_DATA_PORT = 4'h0;
    localparam logic [3:0] PSP_IDX_DATA_LATCH = 4'h1;
    localparam logic [3:0] PSP_IDX_DATA_DIR = 4'h2;
    localparam logic [3:0] PSP_IDX_CTRL_DIR = 4'h3;
    localparam logic [3:0] PSP_IDX_CONTROL = 4'h4;
    localparam logic [3:0] PSP_IDX_FLAGS = 4'h5;
    localparam logic [3:0] PSP_IDX_ENABLES = 4'h6;
    localparam logic [3:0] PSP_IDX_PRIORITY = 4'h7;
    localparam logic [3:0] PSP_IDX_FLAG_CLEAR = 4'h8;
    localparam logic [3:0] PSP_IDX_ANALOG_CFG = 4'h9;
    localparam logic [3:0] PSP_IDX_CTRL_LATCH = 4'ha;

    localparam int PSP_BIT_IBF = 7;
    localparam int PSP_BIT_OBF = 6;
    localparam int PSP_BIT_OVF = 5;
    localparam int PSP_BIT_MODE = 4;
    localparam int PSP_BIT_EVENT = 7;

    localparam logic [7:0] PSP_RST_DIR = 8'hff;
    localparam logic [7:0] PSP_RST_ZERO = 8'h00;
    localparam logic [7:0] PSP_RST_PRIO = 8'hff;
    localparam logic [3:0] PSP_RST_ANALOG = 4'h0;
    localparam logic [2:0] PSP_PCFG_DIGITAL = 3'h7;
    localparam logic [2:0] PSP_CTRL_INPUTS = 3'h7;

    typedef struct packed {
        logic [PSP_AW-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } psp_bus_t;

    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
    } psp_strobe_t;
endpackage : psp_pkg

// ---- core/psp_top.sv ----
/*
 * psp_top: byte-wide parallel slave port with gpio fallback, cpu register
 * port, status flags and a level interrupt.
 * assumes: host pins are already synchronous to core_clk_in; the testbench
 * resolves the pad wires from the output enables.
 */
// Added by the designer: the strobed register port and the register addresses.
// How it works
// - mode bit 4 of control turns the data pins into a host slave port
// - host reads the data latch, or writes the input buffer, as one byte via strobes
// - first cycle with select and write low captures the pin byte
// - from the cycle after select and read go low, the latch byte is driven out
// - slave mode selects ttl thresholds on the control pin buffers
// - input full bit 7 set while a received byte is unread
// - output full bit 6 set until the host reads the byte
// - overflow bit 5 set on write over unread byte; software clears
// - with mode clear, data and control pins are plain gpio
// - control bits 3:0 read as zero
// - slave mode offered only in microcontroller mode, external bus idle
module psp_top
    import psp_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic [psp_pkg::PSP_AW-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic mcu_mode_in,
    input wire logic [7:0] data_pin_in,
    output logic [7:0] data_pin_out,
    output logic [7:0] data_pin_oe_out,
    input wire logic [2:0] ctrl_pin_in,
    output logic [2:0] ctrl_pin_out,
    output logic [2:0] ctrl_pin_oe_out,
    output logic ttl_buffer_sel_out,
    output logic irq_out,
    output logic irq_high_prio_out
);
    import psp_pkg::*;

    psp_bus_t bus;
    psp_strobe_t strb;
    logic [7:0] data_latch_reg;
    logic [7:0] in_buf_reg;
    logic [7:0] data_dir_reg;
    logic [7:0] ctrl_dir_reg;
    logic [2:0] ctrl_latch_reg;
    logic [3:0] analog_cfg_reg;
    logic mode_reg;
    logic ibf_reg;
    logic obf_reg;
    logic ovf_reg;
    logic [7:0] flags_reg;
    logic [7:0] enables_reg;
    logic [7:0] prio_reg;
    logic wr_seen_reg;
    logic rd_seen_reg;
    logic psp_active;
    logic host_wr;
    logic host_rd;
    logic wr_start;
    logic rd_start;
    logic wr_end;
    logic rd_end;
    logic cpu_rd_port;
    logic cpu_wr_port;
    logic [7:0] rdata_next;
    logic [7:0] pending;

    assign bus = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};
    assign strb = '{cs_n: ctrl_pin_in[2], wr_n: ctrl_pin_in[1], rd_n: ctrl_pin_in[0]};

    // microcontroller mode only, no external bus use
    assign psp_active = mode_reg && mcu_mode_in;
    assign host_wr = psp_active && !strb.cs_n && !strb.wr_n;
    assign host_rd = psp_active && !strb.cs_n && !strb.rd_n;
    assign wr_start = host_wr && !wr_seen_reg;
    assign rd_start = host_rd && !rd_seen_reg;
    assign wr_end = wr_seen_reg && !host_wr;
    assign rd_end = rd_seen_reg && !host_rd;
    assign cpu_rd_port = bus.rd && bus.addr == PSP_IDX_DATA_PORT;
    assign cpu_wr_port = bus.wr && (bus.addr == PSP_IDX_DATA_PORT ||
                                    bus.addr == PSP_IDX_DATA_LATCH);

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_seen_reg <= 1'b0;
            rd_seen_reg <= 1'b0;
        end else begin
            wr_seen_reg <= host_wr;
            rd_seen_reg <= host_rd;
        end
    end

    // captured host byte
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            in_buf_reg <= PSP_RST_ZERO;
        end else if (wr_start) begin
            in_buf_reg <= data_pin_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ibf_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end else begin
            if (wr_start) begin
                ibf_reg <= 1'b1;
            end else if (cpu_rd_port && psp_active) begin
                ibf_reg <= 1'b0;
            end
            if (wr_start && ibf_reg) begin
                ovf_reg <= 1'b1;
            end else if (bus.wr && bus.addr == PSP_IDX_CONTROL) begin
                ovf_reg <= bus.wdata[PSP_BIT_OVF];
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            obf_reg <= 1'b0;
        end else if (cpu_wr_port && psp_active) begin
            obf_reg <= 1'b1;
        end else if (rd_start) begin
            obf_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            data_latch_reg <= PSP_RST_ZERO;
            data_dir_reg <= PSP_RST_DIR;
            ctrl_dir_reg <= PSP_RST_DIR;
            ctrl_latch_reg <= 3'h0;
            analog_cfg_reg <= PSP_RST_ANALOG;
            mode_reg <= 1'b0;
            enables_reg <= PSP_RST_ZERO;
            prio_reg <= PSP_RST_PRIO;
        end else if (bus.wr) begin
            if (bus.addr == PSP_IDX_DATA_PORT || bus.addr == PSP_IDX_DATA_LATCH) begin
                data_latch_reg <= bus.wdata;
            end else if (bus.addr == PSP_IDX_DATA_DIR) begin
                data_dir_reg <= bus.wdata;
            end else if (bus.addr == PSP_IDX_CTRL_DIR) begin
                ctrl_dir_reg <= bus.wdata;
            end else if (bus.addr == PSP_IDX_CONTROL) begin
                mode_reg <= bus.wdata[PSP_BIT_MODE];
            end else if (bus.addr == PSP_IDX_ENABLES) begin
                enables_reg <= bus.wdata;
            end else if (bus.addr == PSP_IDX_PRIORITY) begin
                prio_reg <= bus.wdata;
            end else if (bus.addr == PSP_IDX_ANALOG_CFG) begin
                analog_cfg_reg <= bus.wdata[3:0];
            end else if (bus.addr == PSP_IDX_CTRL_LATCH) begin
                ctrl_latch_reg <= bus.wdata[2:0];
            end
        end
    end

    // sticky flags: hardware set beats software clear
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flags_reg <= PSP_RST_ZERO;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (i == PSP_BIT_EVENT && (wr_end || rd_end)) begin
                    flags_reg[i] <= 1'b1;
                end else if (bus.wr && bus.addr == PSP_IDX_FLAG_CLEAR && bus.wdata[i]) begin
                    flags_reg[i] <= 1'b0;
                end
            end
        end
    end

    assign pending = flags_reg & enables_reg;

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_out <= 1'b0;
            irq_high_prio_out <= 1'b0;
        end else begin
            irq_out <= |pending;
            irq_high_prio_out <= |(pending & prio_reg);
        end
    end

    always_comb begin
        rdata_next = 8'h00;
        if (bus.addr == PSP_IDX_DATA_PORT) begin
            rdata_next = psp_active ? in_buf_reg : data_pin_in;
        end else if (bus.addr == PSP_IDX_DATA_LATCH) begin
            rdata_next = data_latch_reg;
        end else if (bus.addr == PSP_IDX_DATA_DIR) begin
            rdata_next = data_dir_reg;
        end else if (bus.addr == PSP_IDX_CTRL_DIR) begin
            rdata_next = ctrl_dir_reg;
        end else if (bus.addr == PSP_IDX_CONTROL) begin
            rdata_next = {ibf_reg, obf_reg, ovf_reg, mode_reg, 4'h0};
        end else if (bus.addr == PSP_IDX_FLAGS) begin
            rdata_next = flags_reg;
        end else if (bus.addr == PSP_IDX_ENABLES) begin
            rdata_next = enables_reg;
        end else if (bus.addr == PSP_IDX_PRIORITY) begin
            rdata_next = prio_reg;
        end else if (bus.addr == PSP_IDX_ANALOG_CFG) begin
            rdata_next = {4'h0, analog_cfg_reg};
        end else if (bus.addr == PSP_IDX_CTRL_LATCH) begin
            rdata_next = {5'h00, ctrl_latch_reg};
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= PSP_RST_ZERO;
        end else if (bus.rd) begin
            reg_rdata_out <= rdata_next;
        end else begin
            reg_rdata_out <= PSP_RST_ZERO;
        end
    end

    // pad drive: slave port drives data only during host read
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            data_pin_out <= PSP_RST_ZERO;
            data_pin_oe_out <= PSP_RST_ZERO;
            ctrl_pin_out <= 3'h0;
            ctrl_pin_oe_out <= 3'h0;
            ttl_buffer_sel_out <= 1'b0;
        end else begin
            data_pin_out <= data_latch_reg;
            if (psp_active) begin
                data_pin_oe_out <= host_rd ? 8'hff : 8'h00;
                ctrl_pin_oe_out <= 3'h0;
            end else begin
                data_pin_oe_out <= ~data_dir_reg;
                ctrl_pin_oe_out <= ~ctrl_dir_reg[2:0];
            end
            ctrl_pin_out <= ctrl_latch_reg;
            ttl_buffer_sel_out <= psp_active;
        end
    end

    property p_write_capture;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        wr_start |=> (in_buf_reg == $past(data_pin_in)) && ibf_reg;
    endproperty
    a_write_capture: assert property (p_write_capture) else $error("byte not captured");

    property p_overflow;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (wr_start && ibf_reg) |=> ovf_reg;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow missed");

    property p_obf_clear;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (rd_start && !(cpu_wr_port && psp_active)) |=> !obf_reg;
    endproperty
    a_obf_clear: assert property (p_obf_clear) else $error("output full stuck");

    sequence s_host_read;
        host_rd ##1 host_rd;
    endsequence
    property p_read_drive;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        s_host_read |-> data_pin_oe_out == 8'hff && data_pin_out == $past(data_latch_reg);
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read not driven");

    property p_event;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (wr_end || rd_end) |=> flags_reg[PSP_BIT_EVENT]
            ##1 (irq_out || !enables_reg[PSP_BIT_EVENT]);
    endproperty
    a_event: assert property (p_event) else $error("event flag missed");

    property p_ibf_cpu_clear;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (cpu_rd_port && psp_active && !wr_start) |=> !ibf_reg;
    endproperty
    a_ibf_cpu_clear: assert property (p_ibf_cpu_clear) else $error("input full kept");

    property p_gpio;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        !psp_active |=> data_pin_oe_out == ~$past(data_dir_reg);
    endproperty
    a_gpio: assert property (p_gpio) else $error("gpio drive wrong");

    property p_low_zero;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (bus.rd && bus.addr == PSP_IDX_CONTROL) |=> reg_rdata_out[3:0] == 4'h0;
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("control low bits set");

    property p_mode_gate;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        !mcu_mode_in |=> !ttl_buffer_sel_out;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("slave mode outside mcu");

    property p_ibf_hold;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (ibf_reg && !(cpu_rd_port && psp_active)) |=> ibf_reg;
    endproperty
    a_ibf_hold: assert property (p_ibf_hold) else $error("input full dropped");

    property p_ibf_idle;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (!ibf_reg && !wr_start) |=> !ibf_reg;
    endproperty
    a_ibf_idle: assert property (p_ibf_idle) else $error("input full without byte");

    property p_obf_set;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (cpu_wr_port && psp_active) |=> obf_reg;
    endproperty
    a_obf_set: assert property (p_obf_set) else $error("output full not set");

    property p_obf_hold;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (obf_reg && !rd_start) |=> obf_reg;
    endproperty
    a_obf_hold: assert property (p_obf_hold) else $error("output full lost early");

    property p_ovf_sticky;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (ovf_reg && !(bus.wr && bus.addr == PSP_IDX_CONTROL)) |=> ovf_reg;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow lost");

    sequence s_host_write;
        wr_start ##1 host_wr;
    endsequence
    property p_write_once;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        s_host_write |=> in_buf_reg == $past(in_buf_reg);
    endproperty
    a_write_once: assert property (p_write_once) else $error("byte captured twice");

    property p_idle_oe;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (psp_active && !host_rd) |=> data_pin_oe_out == 8'h00;
    endproperty
    a_idle_oe: assert property (p_idle_oe) else $error("stray data drive");

    property p_ctrl_input;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        psp_active |=> ctrl_pin_oe_out == 3'h0;
    endproperty
    a_ctrl_input: assert property (p_ctrl_input) else $error("control pin driven");

    property p_gpio_ctrl;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (!psp_active && ctrl_dir_reg[2:0] == PSP_CTRL_INPUTS) |=> ctrl_pin_oe_out == 3'h0;
    endproperty
    a_gpio_ctrl: assert property (p_gpio_ctrl) else $error("control input driven");

    property p_flag_clear;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (bus.wr && bus.addr == PSP_IDX_FLAG_CLEAR && bus.wdata[PSP_BIT_EVENT])
            && !wr_end && !rd_end |=> !flags_reg[PSP_BIT_EVENT];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("event flag kept");

    property p_irq_on;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (|pending) |=> irq_out;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("interrupt missing");

    property p_irq_off;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        !(|pending) |=> !irq_out;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt without cause");
endmodule : psp_top

// ---- dv/psp_host_model.sv ----
/*
 * psp_host_model: external byte-wide microprocessor on the slave port pins.
 * assumes: the bench resolves the pads; strobes move just after a clock edge.
 */
module psp_host_model (
    input wire logic clk_in,
    input wire logic [7:0] pad_in,
    output logic [2:0] ctrl_out,
    output logic [7:0] data_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        ctrl_out = 3'h7;
        data_out = 8'h00;
    end

    // one whole byte per strobe, held for hold_cyc edges, then released
    task automatic host_write(input logic [7:0] b, input int hold_cyc);
        @(posedge clk_in);
        ctrl_out <= 3'b001;
        data_out <= b;
        repeat (hold_cyc) @(posedge clk_in);
        ctrl_out <= 3'h7;
        // released bus does not keep the old byte
        data_out <= ~b;
    endtask : host_write

    task automatic host_read(output logic [7:0] b, input int hold_cyc);
        @(posedge clk_in);
        ctrl_out <= 3'b010;
        repeat (hold_cyc) @(posedge clk_in);
        b = pad_in;
        ctrl_out <= 3'h7;
    endtask : host_read
endmodule : psp_host_model

// ---- dv/psp_top_tb_top.sv ----
/*
 * psp_top_tb_top: register port and host pin tests of the parallel slave port.
 * assumes: psp_host_model stands on the pins; one 100 MHz clock.
 */
module psp_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import psp_pkg::*;

    logic clk, rst_n, wr, rd, mcu_mode, irq, irq_hi, ttl_sel;
    logic [PSP_AW-1:0] addr;
    logic [7:0] wdata, rdata, pad, dout, doe, host_data, got;
    logic [2:0] cpad, cout, coe, host_ctrl;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    logic [11:0] rst_tbl [9] = '{12'h2ff, 12'h3ff, 12'h400, 12'h500, 12'h600,
                                 12'h7ff, 12'h800, 12'h900, 12'hb00};

    assign pad = (doe & dout) | (~doe & host_data);
    assign cpad = (coe & cout) | (~coe & host_ctrl);

    psp_top i_dut (.core_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .mcu_mode_in(mcu_mode), .data_pin_in(pad), .data_pin_out(dout),
        .data_pin_oe_out(doe), .ctrl_pin_in(cpad), .ctrl_pin_out(cout),
        .ctrl_pin_oe_out(coe), .ttl_buffer_sel_out(ttl_sel), .irq_out(irq),
        .irq_high_prio_out(irq_hi));

    psp_host_model i_host (.clk_in(clk), .pad_in(pad), .ctrl_out(host_ctrl),
        .data_out(host_data));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            $display("BAD t=%0t timeout", $time);
            report_and_stop();
        end
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got %h want %h", $time, g, e);
        end
    endtask : chk

    task automatic reg_wr(input logic [PSP_AW-1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [PSP_AW-1:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : reg_rd

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    initial begin
        rst_n = 1'b0;
        addr = '0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        mcu_mode = 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rst_tbl[i]) reg_rd(rst_tbl[i][11:8], rst_tbl[i][7:0]);
        // gpio mode: pins follow latch and direction, host strobes ignored
        reg_wr(PSP_IDX_DATA_LATCH, 8'h5a);
        reg_wr(PSP_IDX_DATA_DIR, 8'h0f);
        reg_wr(PSP_IDX_CTRL_DIR, 8'hfa);
        reg_wr(PSP_IDX_CTRL_LATCH, 8'h05);
        i_host.host_write(8'h00, 2);
        settle();
        chk(doe, 8'hf0);
        chk(dout, 8'h5a);
        chk({5'h00, coe}, 8'h05);
        chk({5'h00, cout}, 8'h05);
        // low nibble is input: released host bus shows the inverse of its last byte
        reg_rd(PSP_IDX_DATA_PORT, 8'h5f);
        reg_rd(PSP_IDX_CONTROL, 8'h00);
        reg_wr(PSP_IDX_CTRL_DIR, 8'h07);
        reg_wr(PSP_IDX_ANALOG_CFG, 8'h07);
        reg_wr(PSP_IDX_DATA_DIR, 8'hff);
        reg_wr(PSP_IDX_ENABLES, 8'h80);
        reg_wr(PSP_IDX_CONTROL, 8'h10);
        settle();
        chk({7'h00, ttl_sel}, 8'h01);
        chk({5'h00, coe}, 8'h00);
        i_host.host_write(8'ha5, 2);
        settle();
        chk({6'h00, irq, irq_hi}, 8'h03);
        reg_rd(PSP_IDX_CONTROL, 8'h90);
        reg_rd(PSP_IDX_FLAGS, 8'h80);
        reg_rd(PSP_IDX_DATA_PORT, 8'ha5);
        reg_rd(PSP_IDX_CONTROL, 8'h10);
        reg_wr(PSP_IDX_FLAG_CLEAR, 8'h80);
        settle();
        chk({7'h00, irq}, 8'h00);
        i_host.host_write(8'h11, 1);
        i_host.host_write(8'h22, 3);
        settle();
        reg_rd(PSP_IDX_CONTROL, 8'hb0);
        reg_rd(PSP_IDX_DATA_PORT, 8'h22);
        reg_rd(PSP_IDX_CONTROL, 8'h30);
        reg_wr(PSP_IDX_CONTROL, 8'h1f);
        reg_rd(PSP_IDX_CONTROL, 8'h10);
        reg_wr(PSP_IDX_PRIORITY, 8'h00);
        settle();
        chk({6'h00, irq, irq_hi}, 8'h02);
        reg_wr(PSP_IDX_ENABLES, 8'h00);
        settle();
        chk({7'h00, irq}, 8'h00);
        reg_wr(PSP_IDX_FLAG_CLEAR, 8'h80);
        reg_wr(PSP_IDX_DATA_PORT, 8'h3c);
        reg_rd(PSP_IDX_CONTROL, 8'h50);
        reg_rd(PSP_IDX_DATA_LATCH, 8'h3c);
        i_host.host_read(got, 4);
        chk(got, 8'h3c);
        settle();
        chk(doe, 8'h00);
        reg_rd(PSP_IDX_CONTROL, 8'h10);
        reg_rd(PSP_IDX_FLAGS, 8'h80);
        @(posedge clk);
        mcu_mode <= 1'b0;
        i_host.host_write(8'h77, 2);
        settle();
        reg_rd(PSP_IDX_CONTROL, 8'h10);
        chk({7'h00, ttl_sel}, 8'h00);
        report_and_stop();
    end
endmodule : psp_top_tb_top
